// File: src/serial_eeprom_read_ops.sv
// Two-wire EEPROM target: read commands, lock probe, serial number area
//
// Overview of operation
// - After acking a read device byte, send byte at counter, then increment.
// - Keep sending successive bytes while the controller acknowledges each one.
// - Main array counter wraps from its last byte to byte zero.
// - Lockable page read: type 1011, address bits 11:9 equal 000.
// - Lockable page index is low seven bits, wrapping within the page.
// - Lock probe data byte is acked when unlocked, refused when locked.
// - Start resets command logic, dropping pending write; Stop returns to idle.
// - Serial number read: type 1011, bits 11:9 equal 001, low four index.
// - Serial number index wraps after the sixteenth byte to the first.
// - Serial number block is read-only; nothing can write it.
// - Device byte: type 1010 or 1011, select bits matching pins, direction.
// - One shared address counter serves main array, page and serial reads.
`timescale 1ns/10ps
`default_nettype none
module serial_eeprom_read_ops
  import eeprom_rd_pkg::*;
#(
  parameter int ADDR_W = 16,
  // Arbitrary neutral contents for the factory serial number
  parameter logic [eeprom_rd_pkg::SN_BITS-1:0] SERIAL_NUMBER =
    128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic link_clk_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n_out,
  input wire logic select_pin_bit2_in,
  input wire logic select_pin_bit1_in,
  input wire logic select_pin_bit0_in,
  input wire logic page_locked_in,
  input wire logic load_en_in,
  input wire logic load_page_in,
  input wire logic [ADDR_W-1:0] load_addr_in,
  input wire logic [7:0] load_data_in
);
  import eeprom_rd_pkg::*;

  localparam int IDX_W = ADDR_W + 1;

  if (ADDR_W < AREA_MSB + 1 || ADDR_W > 16) begin : g_chk
    $error("serial_eeprom_read_ops: ADDR_W must be 12 to 16");
  end

  // ----------------------------------------------------------------
  // Link-side synchronisers
  // ----------------------------------------------------------------
  logic [1:0] rst_sync, scl_sync, sda_sync, lock_sync, ack_sync;
  logic [2:0] sel_s1, sel_s2;
  logic link_rst, scl_s, sda_s, locked_s, scl_q, sda_q;

  always_ff @(posedge link_clk_in) begin
    rst_sync <= {rst_sync[0], sys_rst_in};
    scl_sync <= {scl_sync[0], scl_in};
    sda_sync <= {sda_sync[0], sda_in};
    lock_sync <= {lock_sync[0], page_locked_in};
    sel_s1 <= {select_pin_bit2_in, select_pin_bit1_in, select_pin_bit0_in};
    sel_s2 <= sel_s1;
    scl_q <= scl_s;
    sda_q <= sda_s;
  end
  assign link_rst = rst_sync[1];
  assign scl_s = scl_sync[1];
  assign sda_s = sda_sync[1];
  assign locked_s = lock_sync[1];

  // ----------------------------------------------------------------
  // Bus event decode
  // ----------------------------------------------------------------
  logic scl_rise, scl_fall, start_det, stop_det;
  assign scl_rise = scl_s & ~scl_q;
  assign scl_fall = ~scl_s & scl_q;
  // No glitch filter: a noisy line can fake Start or Stop
  assign start_det = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_det = scl_s & scl_q & ~sda_q & sda_s;

  // Area chosen from type code and address bits 11:9
  function automatic space_t space_of(input logic aux,
                                      input logic [ADDR_W-1:0] a);
    space_t sp;
    sp = SP_MAIN;
    if (aux) begin
      if (a[AREA_MSB:AREA_LSB] == AREA_ID) sp = SP_ID;
      else if (a[AREA_MSB:AREA_LSB] == AREA_SN) sp = SP_SN;
      else sp = SP_NONE;
    end
    return sp;
  endfunction : space_of

  // Counter step with per-area wrap
  function automatic logic [ADDR_W-1:0] step_addr(
      input logic [ADDR_W-1:0] a, input space_t sp);
    logic [ADDR_W-1:0] r;
    r = a;
    case (sp)
      SP_ID: r[ID_IDX_W-1:0] = a[ID_IDX_W-1:0] + 1'b1;
      SP_SN: r[SN_IDX_W-1:0] = a[SN_IDX_W-1:0] + 1'b1;
      default: r = a + 1'b1;
    endcase
    return r;
  endfunction : step_addr

  // ----------------------------------------------------------------
  // Link protocol engine
  // ----------------------------------------------------------------
  link_state_t state_r, state_nxt;
  space_t space_r, space_nxt, sp_sel, fetch_sp_r, fetch_sp_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] rx_r, rx_nxt, tx_r, tx_nxt, hi_r, hi_nxt, rd_data_r;
  logic [ADDR_W-1:0] addr_r, addr_nxt, fetch_addr_r, fetch_addr_nxt;
  logic [ADDR_W-1:0] word_addr, stepped;
  logic [15:0] word_cat;
  logic drive_r, drive_nxt, mack_r, mack_nxt, aux_r, aux_nxt;
  logic req_r, req_nxt, do_load, ack_ok, dev_match, fetch_ready;

  assign word_cat = {hi_r, rx_r};
  assign word_addr = word_cat[ADDR_W-1:0];
  assign fetch_ready = (ack_sync[1] == req_r);
  assign dev_match = ((rx_r[TYPE_MSB:TYPE_LSB] == TYPE_MAIN) ||
                      (rx_r[TYPE_MSB:TYPE_LSB] == TYPE_AUX)) &&
                     (rx_r[SEL_MSB:SEL_LSB] == sel_s2);
  assign sp_sel = (state_r == ST_DEV) ? space_of(rx_r[AUX_BIT], addr_r)
                                      : space_r;
  assign stepped = step_addr(addr_r, sp_sel);

  // Acknowledge decision for bytes the device receives
  always_comb begin
    case (state_r)
      ST_DEV: ack_ok = dev_match;
      ST_ADDR_HI, ST_ADDR_LO: ack_ok = 1'b1;
      ST_WDATA: ack_ok = !(aux_r && locked_s);
      default: ack_ok = 1'b0;
    endcase
  end

  // Next-state logic: bits sampled on SCL rise, driven after SCL fall
  always_comb begin
    state_nxt = state_r;
    space_nxt = space_r;
    cnt_nxt = cnt_r;
    rx_nxt = rx_r;
    tx_nxt = tx_r;
    hi_nxt = hi_r;
    addr_nxt = addr_r;
    drive_nxt = drive_r;
    mack_nxt = mack_r;
    aux_nxt = aux_r;
    req_nxt = req_r;
    fetch_addr_nxt = fetch_addr_r;
    fetch_sp_nxt = fetch_sp_r;
    do_load = 1'b0;
    if (start_det) begin
      state_nxt = ST_DEV;
      cnt_nxt = PRE_SLOT;
      drive_nxt = 1'b0;
    end else if (stop_det) begin
      state_nxt = ST_IDLE;
      cnt_nxt = 4'h0;
      drive_nxt = 1'b0;
    end else if (state_r != ST_IDLE && state_r != ST_IGNORE) begin
      if (scl_rise) begin
        if (cnt_r != ACK_SLOT) rx_nxt = {rx_r[6:0], sda_s};
        else mack_nxt = ~sda_s;
      end else if (scl_fall) begin
        if (cnt_r == PRE_SLOT) begin
          // Counting this fall would put the ack one bit early
          cnt_nxt = 4'h0;
        end else if (cnt_r < LAST_BIT) begin
          cnt_nxt = cnt_r + 4'h1;
          if (state_r == ST_READ) begin
            tx_nxt = {tx_r[6:0], 1'b0};
            drive_nxt = ~tx_r[6];
          end
        end else if (cnt_r == LAST_BIT) begin
          cnt_nxt = ACK_SLOT;
          drive_nxt = ack_ok;
          // Prefetch during the ack slot so the first byte is ready
          if (state_r == ST_DEV && dev_match && rx_r[RW_BIT]) begin
            fetch_addr_nxt = addr_r;
            fetch_sp_nxt = sp_sel;
            req_nxt = ~req_r;
          end
        end else begin
          cnt_nxt = 4'h0;
          drive_nxt = 1'b0;
          case (state_r)
            ST_DEV: begin
              aux_nxt = rx_r[AUX_BIT];
              if (!drive_r) begin
                state_nxt = ST_IGNORE;
              end else if (rx_r[RW_BIT]) begin
                state_nxt = ST_READ;
                space_nxt = sp_sel;
                do_load = 1'b1;
              end else begin
                state_nxt = ST_ADDR_HI;
              end
            end
            ST_ADDR_HI: begin
              hi_nxt = rx_r;
              state_nxt = ST_ADDR_LO;
            end
            ST_ADDR_LO: begin
              addr_nxt = word_addr;
              state_nxt = ST_WDATA;
            end
            ST_READ: begin
              if (mack_r) do_load = 1'b1;
              else state_nxt = ST_IGNORE;
            end
            // Write data is acknowledged unless aux_r and locked_s are both set, but never stored here
            default: state_nxt = state_r;
          endcase
          if (do_load) begin
            tx_nxt = rd_data_r;
            drive_nxt = ~rd_data_r[7];
            addr_nxt = stepped;
            fetch_addr_nxt = stepped;
            fetch_sp_nxt = sp_sel;
            req_nxt = ~req_r;
          end
        end
      end
    end
  end

  always_ff @(posedge link_clk_in) begin
    if (link_rst) begin
      state_r <= ST_IDLE;
      space_r <= SP_MAIN;
      cnt_r <= 4'h0;
      rx_r <= 8'h00;
      tx_r <= 8'h00;
      hi_r <= 8'h00;
      addr_r <= '0;
      drive_r <= 1'b0;
      mack_r <= 1'b0;
      aux_r <= 1'b0;
      req_r <= 1'b0;
      fetch_addr_r <= '0;
      fetch_sp_r <= SP_MAIN;
    end else begin
      state_r <= state_nxt;
      space_r <= space_nxt;
      cnt_r <= cnt_nxt;
      rx_r <= rx_nxt;
      tx_r <= tx_nxt;
      hi_r <= hi_nxt;
      addr_r <= addr_nxt;
      drive_r <= drive_nxt;
      mack_r <= mack_nxt;
      aux_r <= aux_nxt;
      req_r <= req_nxt;
      fetch_addr_r <= fetch_addr_nxt;
      fetch_sp_r <= fetch_sp_nxt;
    end
  end

  // Open-drain: only ever pull low
  assign sda_out = 1'b0;
  assign sda_oe_n_out = ~drive_r;

  // ----------------------------------------------------------------
  // System-side fetch (toggle handshake, words held until answered)
  // ----------------------------------------------------------------
  logic [1:0] req_sync;
  logic seen_r, seen_nxt, wait_r, wait_nxt, ack_r, ack_nxt;
  logic [7:0] rd_data_nxt, mem_q;
  logic [IDX_W-1:0] rd_idx, wr_idx;

  always_ff @(posedge clk_in) begin
    req_sync <= {req_sync[0], req_r};
  end
  always_ff @(posedge link_clk_in) begin
    ack_sync <= {ack_sync[0], ack_r};
  end

  // Page bytes sit above the main array in one store
  always_comb begin
    rd_idx = {1'b0, fetch_addr_r};
    if (fetch_sp_r == SP_ID) begin
      rd_idx = {1'b1, {(ADDR_W-ID_IDX_W){1'b0}},
                fetch_addr_r[ID_IDX_W-1:0]};
    end
    wr_idx = {1'b0, load_addr_in};
    if (load_page_in) begin
      wr_idx = {1'b1, {(ADDR_W-ID_IDX_W){1'b0}},
                load_addr_in[ID_IDX_W-1:0]};
    end
  end

  always_comb begin
    seen_nxt = seen_r;
    wait_nxt = wait_r;
    ack_nxt = ack_r;
    rd_data_nxt = rd_data_r;
    if (wait_r) begin
      wait_nxt = 1'b0;
      ack_nxt = ~ack_r;
      case (fetch_sp_r)
        SP_MAIN, SP_ID: rd_data_nxt = mem_q;
        // Serial bytes come from a constant, no write path exists
        SP_SN: rd_data_nxt =
          SERIAL_NUMBER[{~fetch_addr_r[SN_IDX_W-1:0], 3'h7} -: 8];
        default: rd_data_nxt = FILL_BYTE;
      endcase
    end else if (req_sync[1] != seen_r) begin
      seen_nxt = req_sync[1];
      wait_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      seen_r <= 1'b0;
      wait_r <= 1'b0;
      ack_r <= 1'b0;
      rd_data_r <= FILL_BYTE;
    end else begin
      seen_r <= seen_nxt;
      wait_r <= wait_nxt;
      ack_r <= ack_nxt;
      rd_data_r <= rd_data_nxt;
    end
  end

  byte_store #(.DEPTH(2 ** ADDR_W + ID_BYTES), .IDX_W(IDX_W)) u_store (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .wr_en_in(load_en_in),
    .wr_idx_in(wr_idx),
    .wr_data_in(load_data_in),
    .rd_idx_in(rd_idx),
    .rd_data_out(mem_q)
  );

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge link_clk_in); endclocking
  default disable iff (link_rst);

  dev_ack_a: assert property (
    scl_fall && state_r == ST_DEV && cnt_r == LAST_BIT && dev_match
    |=> drive_r && cnt_r == ACK_SLOT) else $error("device byte not acked");
  fetch_ok_a: assert property (
    do_load |-> fetch_ready) else $error("read byte not fetched in time");
  rd_step_a: assert property (
    do_load |=> addr_r == step_addr($past(addr_r), $past(sp_sel)))
    else $error("counter did not step after byte");
  main_wrap_a: assert property (
    do_load && sp_sel == SP_MAIN && (&addr_r) |=> addr_r == '0)
    else $error("main array did not wrap");
  page_wrap_a: assert property (
    do_load && sp_sel == SP_ID && (&addr_r[ID_IDX_W-1:0])
    |=> addr_r[ID_IDX_W-1:0] == '0 &&
        addr_r[ADDR_W-1:ID_IDX_W] == $past(addr_r[ADDR_W-1:ID_IDX_W]))
    else $error("page index did not wrap in place");
  serial_wrap_a: assert property (
    do_load && sp_sel == SP_SN && (&addr_r[SN_IDX_W-1:0])
    |=> addr_r[SN_IDX_W-1:0] == '0) else $error("serial did not wrap");
  page_area_a: assert property (
    do_load && state_r == ST_DEV && rx_r[AUX_BIT] &&
    addr_r[AREA_MSB:AREA_LSB] == AREA_ID |=> space_r == SP_ID)
    else $error("page area not selected");
  serial_area_a: assert property (
    do_load && state_r == ST_DEV && rx_r[AUX_BIT] &&
    addr_r[AREA_MSB:AREA_LSB] == AREA_SN |=> space_r == SP_SN)
    else $error("serial area not selected");
  lock_probe_a: assert property (
    scl_fall && state_r == ST_WDATA && cnt_r == LAST_BIT && aux_r
    |=> drive_r == !$past(locked_s)) else $error("lock probe answer wrong");
  start_clear_a: assert property (
    start_det |=> state_r == ST_DEV && cnt_r == PRE_SLOT && !drive_r)
    else $error("start did not reset command logic");
  stop_idle_a: assert property (
    stop_det |=> state_r == ST_IDLE ##1 !drive_r)
    else $error("stop did not return to idle");
  seq_more_a: assert property (
    scl_fall && state_r == ST_READ && cnt_r == ACK_SLOT && mack_r
    |=> state_r == ST_READ && drive_r == !tx_r[7])
    else $error("sequential read stopped while acked");

  random_rd_c: cover property (state_r == ST_ADDR_LO ##[1:1000] do_load);
  page_wrap_c: cover property (do_load && sp_sel == SP_ID &&
                               (&addr_r[ID_IDX_W-1:0]));
  serial_rd_c: cover property (do_load && sp_sel == SP_SN);
  lock_nack_c: cover property (scl_fall && state_r == ST_WDATA &&
                               cnt_r == LAST_BIT && aux_r && locked_s);
endmodule : serial_eeprom_read_ops
`default_nettype wire

// File: src/eeprom_rd_pkg.sv
// Shared constants and types for the serial EEPROM read-side target
package eeprom_rd_pkg;
  // ----------------------------------------------------------------
  // Device address byte layout
  // ----------------------------------------------------------------
  localparam logic [3:0] TYPE_MAIN = 4'ha;
  localparam logic [3:0] TYPE_AUX = 4'hb;
  localparam int TYPE_MSB = 7;
  localparam int TYPE_LSB = 4;
  localparam int AUX_BIT = 4;
  localparam int SEL_MSB = 3;
  localparam int SEL_LSB = 1;
  localparam int RW_BIT = 0;
  // ----------------------------------------------------------------
  // Word address layout of the auxiliary areas
  // ----------------------------------------------------------------
  localparam int AREA_MSB = 11;
  localparam int AREA_LSB = 9;
  localparam logic [2:0] AREA_ID = 3'h0;
  localparam logic [2:0] AREA_SN = 3'h1;
  localparam int ID_IDX_W = 7;
  localparam int ID_BYTES = 128;
  localparam int SN_IDX_W = 4;
  localparam int SN_BITS = 128;
  // ----------------------------------------------------------------
  // Bit slots within one byte frame, fill value
  // ----------------------------------------------------------------
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  // Marks the SCL fall that closes a Start; it is not a bit slot
  localparam logic [3:0] PRE_SLOT = 4'hf;
  localparam logic [7:0] FILL_BYTE = 8'hff;

  typedef enum logic [1:0] {
    SP_MAIN = 2'b00,
    SP_ID = 2'b01,
    SP_SN = 2'b10,
    SP_NONE = 2'b11
  } space_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DEV = 3'b001,
    ST_ADDR_HI = 3'b010,
    ST_ADDR_LO = 3'b011,
    ST_WDATA = 3'b100,
    ST_READ = 3'b101,
    ST_IGNORE = 3'b110
  } link_state_t;
endpackage : eeprom_rd_pkg

// File: src/byte_store.sv
// Byte memory with one write port and a registered read port
`timescale 1ns/10ps
`default_nettype none
module byte_store #(
  parameter int DEPTH = 65664,
  parameter int IDX_W = 17
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic wr_en_in,
  input wire logic [IDX_W-1:0] wr_idx_in,
  input wire logic [7:0] wr_data_in,
  input wire logic [IDX_W-1:0] rd_idx_in,
  output logic [7:0] rd_data_out
);
  logic [7:0] mem [DEPTH];

  if (DEPTH > (2 ** IDX_W)) begin : g_chk
    $error("byte_store: index too narrow for depth");
  end

  // ----------------------------------------------------------------
  // Storage and read register
  // ----------------------------------------------------------------
  // Array itself carries no reset so it can map onto block memory
  always_ff @(posedge clk_in) begin
    if (wr_en_in) begin
      mem[wr_idx_in] <= wr_data_in;
    end
  end

  // Read data always from a flop, cleared by reset
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rd_data_out <= 8'h00;
    end else begin
      rd_data_out <= mem[rd_idx_in];
    end
  end
endmodule : byte_store
`default_nettype wire

// File: testbench/bus_master_model.sv
// Two-wire bus controller model: frames, bytes and acknowledge slots
`timescale 1ns/10ps
`default_nettype none
module bus_master_model #(
  parameter int QTR_NS = 400
) (
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_rel_out
);
  // Both lines released at rest; SCL stands high between frames
  initial begin
    scl_out = 1'b1;
    sda_rel_out = 1'b1;
  end

  // Start or repeated Start; SDA falls only while SCL is high
  task automatic start_cond();
    #QTR_NS;
    sda_rel_out = 1'b1;
    #QTR_NS;
    scl_out = 1'b1;
    #QTR_NS;
    sda_rel_out = 1'b0;
    #QTR_NS;
    scl_out = 1'b0;
  endtask : start_cond

  // Stop, then bus free time before anything else
  task automatic stop_cond();
    #QTR_NS;
    sda_rel_out = 1'b0;
    #QTR_NS;
    scl_out = 1'b1;
    #QTR_NS;
    sda_rel_out = 1'b1;
    #QTR_NS;
  endtask : stop_cond

  // One bit slot; data moves a quarter into the low phase, clear of edges
  task automatic clock_bit(input logic b, output logic r);
    #QTR_NS;
    sda_rel_out = b;
    #QTR_NS;
    scl_out = 1'b1;
    #QTR_NS;
    r = sda_in;
    scl_out = 1'b0;
  endtask : clock_bit

  // Byte out MSB first, then the target's acknowledge slot
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(d[i], r);
    end
    clock_bit(1'b1, r);
    ack = ~r;
  endtask : send_byte

  // Byte in MSB first; ack low ends the read with a refusal
  task automatic recv_byte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(1'b1, r);
      d[i] = r;
    end
    clock_bit(~ack, r);
  endtask : recv_byte

  // Address preload: device byte, high then low word address byte
  task automatic dummy_write(input logic [7:0] dev, input logic [15:0] a,
                             output logic ok);
    logic k0, k1, k2;
    start_cond();
    send_byte(dev, k0);
    send_byte(a[15:8], k1);
    send_byte(a[7:0], k2);
    ok = k0 & k1 & k2;
  endtask : dummy_write
endmodule : bus_master_model
`default_nettype wire

// File: testbench/serial_eeprom_read_ops_tb.sv
// Self-checking bench for the two-wire EEPROM read-side target
`timescale 1ns/10ps
`default_nettype none
module serial_eeprom_read_ops_tb;
  import eeprom_rd_pkg::*;
  localparam int AW = 12;
  // Arbitrary serial contents chosen by the bench
  localparam logic [127:0] SN_VAL = 128'h8899aabbccddeeff0011223344556677;
  localparam logic [11:0] MAIN_LIST [8] = '{12'h123, 12'h124, 12'hffe,
    12'hfff, 12'h000, 12'h001, 12'h002, 12'h003};
  localparam logic [6:0] ID_LIST [4] = '{7'h7e, 7'h7f, 7'h00, 7'h04};
  logic clk_in, link_clk, sys_rst, scl, sda_rel, sda_out, sda_oe_n, ok;
  logic [2:0] sel;
  logic page_locked, load_en, load_page;
  logic [AW-1:0] load_addr;
  logic [7:0] load_data;
  logic [7:0] exp_q[$];
  wire logic sda_wire;
  int n_errors = 0;
  int tests_run = 0;

  // Pulled-up wire: either party may only pull it low
  assign sda_wire = sda_rel & (sda_oe_n | sda_out);

  // System clock 20 ns; link clock 32 ns with its own phase
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #16 link_clk = ~link_clk;
  end

  serial_eeprom_read_ops #(.ADDR_W(AW), .SERIAL_NUMBER(SN_VAL))
    i_serial_eeprom_read_ops (.clk_in(clk_in), .sys_rst_in(sys_rst),
    .link_clk_in(link_clk), .scl_in(scl), .sda_in(sda_wire),
    .sda_out(sda_out), .sda_oe_n_out(sda_oe_n),
    .select_pin_bit2_in(sel[2]), .select_pin_bit1_in(sel[1]),
    .select_pin_bit0_in(sel[0]), .page_locked_in(page_locked),
    .load_en_in(load_en), .load_page_in(load_page),
    .load_addr_in(load_addr), .load_data_in(load_data));
  bus_master_model i_bus_master_model (.sda_in(sda_wire), .scl_out(scl),
    .sda_rel_out(sda_rel));

  // Known contents, never derived from the design
  function automatic logic [7:0] mpat(input logic [AW-1:0] a);
    return a[7:0] ^ {a[11:8], 4'h9};
  endfunction : mpat
  function automatic logic [7:0] ipat(input logic [6:0] i);
    return {1'b1, i} ^ 8'h42;
  endfunction : ipat
  function automatic logic [7:0] snb(input int i);
    return SN_VAL[127-8*i -: 8];
  endfunction : snb
  function automatic logic [7:0] dev(input logic [3:0] typ, input logic rw);
    return {typ, sel, rw};
  endfunction : dev

  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("Checks made %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish

  // Preload one byte through the clk_in-domain load port
  task automatic load(input logic pg, input logic [AW-1:0] a,
                      input logic [7:0] d);
    @(posedge clk_in);
    #2;
    load_en = 1'b1;
    load_page = pg;
    load_addr = a;
    load_data = d;
    @(posedge clk_in);
    #2;
    load_en = 1'b0;
  endtask : load

  // Read direction frame: acks all queued bytes but the last, then Stop
  task automatic rd_run(input logic [7:0] dv, input string what);
    logic ack;
    logic [7:0] d;
    i_bus_master_model.start_cond();
    i_bus_master_model.send_byte(dv, ack);
    check({what, " device ack"}, {7'h00, ack}, 8'h01);
    foreach (exp_q[i]) begin
      i_bus_master_model.recv_byte(i < exp_q.size() - 1, d);
      check(what, d, exp_q[i]);
    end
    i_bus_master_model.stop_cond();
    exp_q.delete();
  endtask : rd_run

  // Address preload with its acknowledge check, then a read frame
  task automatic addr_rd(input logic [3:0] typ, input logic [15:0] a,
                         input string what);
    i_bus_master_model.dummy_write(dev(typ, 1'b0), a, ok);
    check({what, " preload acks"}, {7'h00, ok}, 8'h01);
    rd_run(dev(typ, 1'b1), what);
  endtask : addr_rd

  // Upper bound: well over the ~1.1 ms that the tests take
  initial begin
    #1_800_000;
    n_errors++;
    tally_and_finish();
  end

  initial begin
    logic ack;
    sys_rst = 1'b1;
    sel = 3'b010;
    page_locked = 1'b0;
    load_en = 1'b0;
    load_page = 1'b0;
    load_addr = '0;
    load_data = '0;
    repeat (16) @(posedge clk_in);
    #2;
    sys_rst = 1'b0;
    repeat (8) @(posedge clk_in);
    foreach (MAIN_LIST[i]) load(1'b0, MAIN_LIST[i], mpat(MAIN_LIST[i]));
    foreach (ID_LIST[i]) load(1'b1, {5'h00, ID_LIST[i]}, ipat(ID_LIST[i]));

    exp_q.push_back(mpat(12'h123));
    exp_q.push_back(mpat(12'h124));
    addr_rd(TYPE_MAIN, 16'h0123, "random read");
    $display("Test random read done");

    // Last two bytes of the array, then on through address zero
    for (int k = 0; k < 4; k++) exp_q.push_back(mpat(AW'(12'hffe + k)));
    addr_rd(TYPE_MAIN, 16'h0ffe, "array wrap");
    exp_q.push_back(mpat(12'h002));
    rd_run(dev(TYPE_MAIN, 1'b1), "current read");
    $display("Test array wrap done");

    // Counter left by a main read selects the page byte next
    exp_q.push_back(mpat(12'h003));
    addr_rd(TYPE_MAIN, 16'h0003, "shared counter");
    exp_q.push_back(ipat(7'h04));
    rd_run(dev(TYPE_AUX, 1'b1), "shared counter aux");
    $display("Test shared counter done");

    // Ignored bits set; index wraps inside the page
    foreach (ID_LIST[i]) if (i < 3) exp_q.push_back(ipat(ID_LIST[i]));
    addr_rd(TYPE_AUX, 16'hf1fe, "page wrap");
    $display("Test page read done");

    for (int k = 0; k < 17; k++) exp_q.push_back(snb(k % 16));
    addr_rd(TYPE_AUX, 16'h0200, "serial full");
    exp_q.push_back(snb(14));
    exp_q.push_back(snb(15));
    addr_rd(TYPE_AUX, 16'hf3fe, "serial offset");
    // Unselected auxiliary area reads the fill value
    exp_q.push_back(FILL_BYTE);
    addr_rd(TYPE_AUX, 16'h0400, "empty area");
    // A write frame aimed at the serial block must leave it unchanged
    i_bus_master_model.dummy_write(dev(TYPE_AUX, 1'b0), 16'h0200, ok);
    i_bus_master_model.send_byte(8'h00, ack);
    i_bus_master_model.stop_cond();
    exp_q.push_back(snb(0));
    addr_rd(TYPE_AUX, 16'h0200, "serial kept");
    $display("Test serial number done");

    // Lock probe in both states; Start then Stop drops the write
    for (int lk = 0; lk < 2; lk++) begin
      @(posedge clk_in);
      #2;
      page_locked = lk[0];
      repeat (10) @(posedge clk_in);
      i_bus_master_model.dummy_write(dev(TYPE_AUX, 1'b0), 16'h0004, ok);
      i_bus_master_model.send_byte(8'h55, ack);
      check("lock probe ack", {7'h00, ack}, {7'h00, ~lk[0]});
      i_bus_master_model.start_cond();
      i_bus_master_model.stop_cond();
      exp_q.push_back(ipat(7'h04));
      addr_rd(TYPE_AUX, 16'h0004, "probe discarded");
    end
    $display("Test lock probe done");

    // Stale select bits and a foreign type code are both refused
    @(posedge clk_in);
    #2;
    sel = 3'b101;
    repeat (10) @(posedge clk_in);
    i_bus_master_model.start_cond();
    i_bus_master_model.send_byte({TYPE_MAIN, 3'b010, 1'b1}, ack);
    check("select mismatch", {7'h00, ack}, 8'h00);
    i_bus_master_model.start_cond();
    i_bus_master_model.send_byte({4'h9, sel, 1'b1}, ack);
    check("bad type", {7'h00, ack}, 8'h00);
    i_bus_master_model.stop_cond();
    exp_q.push_back(mpat(12'h123));
    addr_rd(TYPE_MAIN, 16'h0123, "new select");
    $display("Test addressing done");
    tally_and_finish();
  end
endmodule : serial_eeprom_read_ops_tb
`default_nettype wire
